// ===== core/ddi_top.sv
// ddr sample input, fifo, divider and serial pin control of a dual dac
// Contract
// - 3-wire mode: serial data line drives read data
// - 4-wire mode: serial data line is input only
// - 4-wire mode: read data on dedicated output
// - 3-wire mode: dedicated output stays undriven
// - serial clear is active low, asynchronous
// - gate low forces datapath to zeros
// - sleep input high puts block asleep
// - one word captured per word clock edge
// - rising edge word is A, falling B
// - top data line is sample msb unless reversed
// - pointer strobe sampled on rising word edge
// - phase strobe resets divider and fifo read
// - idle phase strobe means normal operation
// - sample codes are offset binary, passed unchanged
`timescale 1ns/1ps
module ddi_top
(
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    input  wire logic                  serial_port_clear_n,
    input  wire logic                  cfg_load,
    input  wire logic                  cfg_four_wire,
    input  wire logic                  cfg_bus_reverse,
    input  wire logic                  serial_read_active,
    input  wire logic                  serial_read_bit,
    input  wire logic                  serial_data_in,
    output logic                       serial_data_out,
    output logic                       serial_data_oe,
    output logic                       serial_read_out,
    output logic                       serial_read_oe,
    output logic                       serial_rx_bit,
    input  wire logic                  transmit_gate,
    input  wire logic                  sleep_in,
    input  wire logic                  forwarded_word_clock,
    input  wire logic [ddi_pkg::WORD_W-1:0] word_bus,
    input  wire logic                  fifo_pointer_strobe,
    input  wire logic                  converter_clock,
    input  wire logic                  divider_phase_strobe,
    output logic [ddi_pkg::WORD_W-1:0] dac_a_code,
    output logic [ddi_pkg::WORD_W-1:0] dac_b_code,
    output logic                       dac_update,
    output logic [ddi_pkg::DIV_W-1:0]  divider_phase,
    output logic                       sleep_state,
    output logic                       fifo_overflow
);
    import ddi_pkg::*;

    logic [SYNC_W-1:0] pins_s;
    ddi_word_type      data_s;
    logic              wclk_s, strobe_s, gate_s, sleep_s, cclk_s, align_s;
    logic              cfg_rst;
    logic              four_wire_reg, four_wire_next;
    logic              reverse_reg, reverse_next;
    logic              sdio_out_reg, sdio_out_next;
    logic              sdio_oe_reg, sdio_oe_next;
    logic              sdo_out_reg, sdo_out_next;
    logic              sdo_oe_reg, sdo_oe_next;
    logic              wclk_d_reg, cclk_d_reg;
    logic              word_rise, word_fall;
    logic              align_hit, sync_hit;
    ddi_word_type      word_a_reg, word_a_next;
    ddi_word_type      word_now;
    logic              push_valid, push_ready;
    ddi_pair_type      push_data;
    logic              ovf_reg, ovf_next;
    logic              pop;
    logic              fifo_valid;
    ddi_pair_type      fifo_data;
    logic              fifo_full, fifo_empty;
    logic [DIV_W-1:0]  div_reg, div_next;
    ddi_word_type      dac_a_reg, dac_a_next;
    ddi_word_type      dac_b_reg, dac_b_next;
    logic              upd_reg, upd_next;
    logic              sleep_reg;

    // line order of a word; used for both channels
    function automatic ddi_word_type order_word(input ddi_word_type w,
                                                input logic rev);
        ddi_word_type r;
        for (int i = 0; i < WORD_W; i++)
        begin
            r[i] = rev ? w[WORD_W-1-i] : w[i];
        end
        return r;
    endfunction

    // every pin input except the serial clear, data lines included, passes two flops
    ddi_sync #(
        .W(SYNC_W)
    ) u_sync (
        .core_clk(core_clk),
        .rst     (rst),
        .d       ({serial_data_in, divider_phase_strobe, converter_clock,
                   sleep_in, transmit_gate, fifo_pointer_strobe,
                   forwarded_word_clock, word_bus}),
        .q       (pins_s)
    );

    assign data_s   = pins_s[WORD_W-1:0];
    assign wclk_s   = pins_s[PIN_WCLK];
    assign strobe_s = pins_s[PIN_STRB];
    assign gate_s   = pins_s[PIN_GATE];
    assign sleep_s  = pins_s[PIN_SLEEP];
    assign cclk_s   = pins_s[PIN_CCLK];
    // pad pull-down keeps an unconnected strobe low, i.e. inactive
    assign align_s  = pins_s[PIN_ALIGN];
    assign serial_rx_bit = pins_s[PIN_SDIO];

    // config register; serial clear acts without a clock
    assign cfg_rst = rst || !serial_port_clear_n;
    always_comb
    begin
        four_wire_next = four_wire_reg;
        reverse_next   = reverse_reg;
        if (cfg_load)
        begin
            four_wire_next = cfg_four_wire;
            reverse_next   = cfg_bus_reverse;
        end
    end

    always_ff @(posedge core_clk or posedge cfg_rst)
    begin
        if (cfg_rst)
        begin
            four_wire_reg <= CFG_FOUR_WIRE_RST;
            reverse_reg   <= CFG_REVERSE_RST;
        end
        else
        begin
            four_wire_reg <= four_wire_next;
            reverse_reg   <= reverse_next;
        end
    end

    // serial pin steering by wire mode
    always_comb
    begin
        sdio_oe_next  = !four_wire_reg && serial_read_active;
        sdio_out_next = sdio_oe_next && serial_read_bit;
        sdo_oe_next   = four_wire_reg;
        sdo_out_next  = four_wire_reg && serial_read_active
                        && serial_read_bit;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sdio_oe_reg  <= 1'h0;
            sdio_out_reg <= 1'h0;
            sdo_oe_reg   <= 1'h0;
            sdo_out_reg  <= 1'h0;
        end
        else
        begin
            sdio_oe_reg  <= sdio_oe_next;
            sdio_out_reg <= sdio_out_next;
            sdo_oe_reg   <= sdo_oe_next;
            sdo_out_reg  <= sdo_out_next;
        end
    end

    // edges of the sampled word and converter clocks
    assign word_rise = wclk_s && !wclk_d_reg;
    assign word_fall = !wclk_s && wclk_d_reg;
    assign sync_hit  = word_rise && strobe_s;
    assign align_hit = cclk_s && !cclk_d_reg && align_s;
    assign word_now  = gate_s ? order_word(data_s, reverse_reg)
                              : WORD_ZERO;

    // rising word held as A, paired with the falling word B
    always_comb
    begin
        word_a_next = word_a_reg;
        if (word_rise)
        begin
            word_a_next = word_now;
        end
        push_valid = word_fall;
        push_data  = {word_a_reg, word_now};
        // link cannot stall: a refused pair is dropped and flagged
        ovf_next = ovf_reg && !sync_hit;
        if (push_valid && !push_ready)
        begin
            ovf_next = 1'h1;
        end
    end

    ddi_fifo #(
        .WIDTH(PAIR_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .rst      (rst),
        .wr_flush (sync_hit),
        .rd_flush (align_hit),
        .in_valid (push_valid),
        .in_ready (push_ready),
        .in_data  (push_data),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data (fifo_data),
        .full     (fifo_full),
        .empty    (fifo_empty)
    );

    // read side: one pair per rising converter edge unless asleep or aligning
    always_comb
    begin
        pop      = cclk_s && !cclk_d_reg && fifo_valid && !sleep_s
                   && !align_hit;
        div_next = div_reg;
        if (align_hit)
        begin
            div_next = DIV_ZERO;
        end
        else if (cclk_s && !cclk_d_reg)
        begin
            div_next = div_reg + DIV_STEP;
        end
        dac_a_next = dac_a_reg;
        dac_b_next = dac_b_reg;
        if (sleep_s || !gate_s)
        begin
            dac_a_next = WORD_ZERO;
            dac_b_next = WORD_ZERO;
        end
        else if (pop)
        begin
            dac_a_next = fifo_data[PAIR_W-1:PAIR_A_LSB];
            dac_b_next = fifo_data[WORD_W-1:0];
        end
        upd_next = pop;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wclk_d_reg <= 1'h0;
            cclk_d_reg <= 1'h0;
            word_a_reg <= WORD_ZERO;
            ovf_reg    <= 1'h0;
            div_reg    <= DIV_ZERO;
            dac_a_reg  <= WORD_ZERO;
            dac_b_reg  <= WORD_ZERO;
            upd_reg    <= 1'h0;
            sleep_reg  <= 1'h0;
        end
        else
        begin
            wclk_d_reg <= wclk_s;
            cclk_d_reg <= cclk_s;
            word_a_reg <= word_a_next;
            ovf_reg    <= ovf_next;
            div_reg    <= div_next;
            dac_a_reg  <= dac_a_next;
            dac_b_reg  <= dac_b_next;
            upd_reg    <= upd_next;
            sleep_reg  <= sleep_s;
        end
    end

    assign serial_data_out = sdio_out_reg;
    assign serial_data_oe  = sdio_oe_reg;
    assign serial_read_out = sdo_out_reg;
    assign serial_read_oe  = sdo_oe_reg;
    assign dac_a_code      = dac_a_reg;
    assign dac_b_code      = dac_b_reg;
    assign dac_update      = upd_reg;
    assign divider_phase   = div_reg;
    assign sleep_state     = sleep_reg;
    assign fifo_overflow   = ovf_reg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_SDIO_DRIVE: assert property (
        (!four_wire_reg && serial_read_active) |=> serial_data_oe
            && (serial_data_out == $past(serial_read_bit)))
        else $error("serial data line not driven in 3-wire read");
    AST_SDIO_QUIET: assert property (
        (four_wire_reg && $past(four_wire_reg)) |-> !serial_data_oe)
        else $error("serial data line driven in 4-wire mode");
    AST_SDO_DRIVE: assert property (
        (four_wire_reg && serial_read_active) |=> serial_read_oe
            && (serial_read_out == $past(serial_read_bit)))
        else $error("read output wrong in 4-wire mode");
    AST_SDO_HIZ: assert property (
        (!four_wire_reg && !$past(four_wire_reg)) |-> !serial_read_oe)
        else $error("read output driven in 3-wire mode");
    AST_CFG_CLEAR: assert property (
        !serial_port_clear_n |-> (four_wire_reg == CFG_FOUR_WIRE_RST)
            && (reverse_reg == CFG_REVERSE_RST))
        else $error("config not cleared by serial clear");
    AST_GATE_ZERO: assert property (
        (word_rise && !gate_s) |=> (word_a_reg == WORD_ZERO))
        else $error("gated word not forced to zero");
    AST_SLEEP_OUT: assert property (
        sleep_s |=> sleep_state && !dac_update
            && (dac_a_code == WORD_ZERO))
        else $error("sleep not honoured");
    AST_CAPTURE_A: assert property (
        (word_rise && gate_s) |=>
            (word_a_reg == order_word($past(data_s), $past(reverse_reg))))
        else $error("channel A word not captured on rising edge");
    AST_PUSH_FALL: assert property (
        (word_fall && !align_hit) |=> !fifo_empty)
        else $error("falling edge pair not stored in fifo");
    AST_SYNC_FLUSH: assert property (
        sync_hit |=> fifo_empty && !fifo_overflow)
        else $error("pointer strobe did not reset fifo");
    AST_ALIGN_RESET: assert property (
        align_hit |=> (divider_phase == DIV_ZERO) && !dac_update)
        else $error("phase strobe did not reset divider");
    AST_ALIGN_IDLE: assert property (
        (cclk_s && !cclk_d_reg && !align_s) |=>
            (divider_phase == $past(div_reg) + DIV_STEP))
        else $error("divider did not advance with idle strobe");
    AST_OFFSET_PASS: assert property (
        (pop && gate_s) |=> dac_update
            && (dac_a_code == $past(fifo_data[PAIR_W-1:PAIR_A_LSB]))
            && (dac_b_code == $past(fifo_data[WORD_W-1:0])))
        else $error("sample code altered on its way out");

    COV_SYNC: cover property (sync_hit ##1 fifo_empty);
    COV_ALIGN: cover property (align_hit);
    COV_FULL: cover property (fifo_full ##1 fifo_overflow);
    COV_FOUR_WIRE_READ: cover property (four_wire_reg && serial_read_active);
endmodule

// ===== core/ddi_pkg.sv
// shared constants for the dual converter ddr input interface
package ddi_pkg;
    localparam int WORD_W    = 12;
    localparam int PAIR_W    = 2 * WORD_W;
    localparam int PAIR_A_LSB = WORD_W;
    localparam int FIFO_DEPTH = 16;
    localparam int DIV_W     = 2;
    localparam int SYNC_W    = WORD_W + 7;
    // bit positions inside the synchronised pin vector
    localparam int PIN_WCLK  = WORD_W;
    localparam int PIN_STRB  = WORD_W + 1;
    localparam int PIN_GATE  = WORD_W + 2;
    localparam int PIN_SLEEP = WORD_W + 3;
    localparam int PIN_CCLK  = WORD_W + 4;
    localparam int PIN_ALIGN = WORD_W + 5;
    localparam int PIN_SDIO  = WORD_W + 6;
    // configuration defaults: 3-wire port, bus not reversed
    localparam logic CFG_FOUR_WIRE_RST = 1'h0;
    localparam logic CFG_REVERSE_RST   = 1'h0;
    localparam logic [WORD_W-1:0] WORD_ZERO = 12'h000;
    localparam logic [DIV_W-1:0]  DIV_ZERO  = 2'h0;
    localparam logic [DIV_W-1:0]  DIV_STEP  = 2'h1;
    typedef logic [WORD_W-1:0] ddi_word_type;
    typedef logic [PAIR_W-1:0] ddi_pair_type;
endpackage

// ===== core/ddi_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module ddi_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    // first stage feeds only the second stage
    always_comb
    begin
        meta_next = d;
        q_next    = meta_reg;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_reg <= '0;
            q_reg    <= '0;
        end
        else
        begin
            meta_reg <= meta_next;
            q_reg    <= q_next;
        end
    end

    assign q = q_reg;
endmodule

// ===== core/ddi_fifo.sv
// sample pair fifo with independent write and read side flush
`timescale 1ns/1ps
module ddi_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             wr_flush,
    input  wire logic             rd_flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  full,
    output logic                  empty
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] PTR_ZERO = '0;
    localparam logic [AW:0] PTR_ONE  = {{AW{1'h0}}, 1'h1};

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      wr_ptr_next;
    logic [AW:0]      rd_ptr_reg;
    logic [AW:0]      rd_ptr_next;
    logic [AW:0]      wr_adv;
    logic [AW:0]      rd_adv;
    logic             push;
    logic             pop;

    // extra pointer bit tells full from empty
    assign empty     = (wr_ptr_reg == rd_ptr_reg);
    assign full      = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0])
                     && (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_ptr_reg[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // a flush snaps its pointer onto the other side, leaving it empty
    always_comb
    begin
        wr_adv = push ? wr_ptr_reg + PTR_ONE : wr_ptr_reg;
        rd_adv = pop ? rd_ptr_reg + PTR_ONE : rd_ptr_reg;
        wr_ptr_next = wr_adv;
        rd_ptr_next = rd_adv;
        if (wr_flush && rd_flush)
        begin
            wr_ptr_next = PTR_ZERO;
            rd_ptr_next = PTR_ZERO;
        end
        else if (wr_flush)
        begin
            wr_ptr_next = rd_adv;
        end
        else if (rd_flush)
        begin
            rd_ptr_next = wr_adv;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_reg <= PTR_ZERO;
            rd_ptr_reg <= PTR_ZERO;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
        end
    end

    // storage carries no reset; contents behind the pointers are unused
    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end
endmodule

// ===== bench/ddi_host_model.sv
// host side model: ddr word source with forwarded clock and pointer strobe
`timescale 1ns/1ps
module ddi_host_model
    import ddi_pkg::*;
#(
    parameter int HALF = 4
) (
    input  wire logic                  core_clk,
    output logic                       forwarded_word_clock,
    output logic [ddi_pkg::WORD_W-1:0] word_bus,
    output logic                       fifo_pointer_strobe
);
    // idle levels at time zero
    initial
    begin
        forwarded_word_clock = 1'b0;
        word_bus             = 12'h000;
        fifo_pointer_strobe  = 1'b0;
    end

    // one word clock period carries one pair; clock rests low between
    task automatic send_pair(input ddi_word_type a, input ddi_word_type b,
                             input logic strobe);
        @(posedge core_clk);
        forwarded_word_clock <= 1'b1;
        word_bus             <= a;
        fifo_pointer_strobe  <= strobe;
        // half period of several core cycles so the edge is sampled
        repeat (HALF) @(posedge core_clk);
        forwarded_word_clock <= 1'b0;
        word_bus             <= b;
        fifo_pointer_strobe  <= 1'b0;
        repeat (HALF) @(posedge core_clk);
        // hold over: show a changed value so nothing stale is reused
        word_bus <= ~b;
    endtask
endmodule

// ===== bench/testbench.sv
// self-checking bench for the dual converter ddr input block
`timescale 1ns/1ps
module testbench;
    import ddi_pkg::*;
    logic core_clk, rst, clear_n, cfg_load, cfg_four, cfg_rev;
    logic rd_act, rd_bit, sdio_drv, gate, sleep_in, cclk, align;
    logic cclk_run;
    logic [1:0] ccnt;
    logic wclk, strobe, sd_out, sd_oe, rd_out, rd_oe, rx_bit, upd;
    logic sleep_st, ovf;
    logic [WORD_W-1:0] word, code_a, code_b;
    logic [DIV_W-1:0] phase;
    wire sdio_wire = sd_oe ? sd_out : sdio_drv;
    int fails, n_tests;

    ddi_top i_ddi_top (
        .core_clk(core_clk), .rst(rst), .serial_port_clear_n(clear_n),
        .cfg_load(cfg_load), .cfg_four_wire(cfg_four),
        .cfg_bus_reverse(cfg_rev), .serial_read_active(rd_act),
        .serial_read_bit(rd_bit), .serial_data_in(sdio_wire),
        .serial_data_out(sd_out), .serial_data_oe(sd_oe),
        .serial_read_out(rd_out), .serial_read_oe(rd_oe),
        .serial_rx_bit(rx_bit), .transmit_gate(gate),
        .sleep_in(sleep_in), .forwarded_word_clock(wclk),
        .word_bus(word), .fifo_pointer_strobe(strobe),
        .converter_clock(cclk), .divider_phase_strobe(align),
        .dac_a_code(code_a), .dac_b_code(code_b), .dac_update(upd),
        .divider_phase(phase), .sleep_state(sleep_st),
        .fifo_overflow(ovf)
    );

    ddi_host_model i_ddi_host_model (
        .core_clk(core_clk), .forwarded_word_clock(wclk),
        .word_bus(word), .fifo_pointer_strobe(strobe)
    );

    always #10 core_clk = ~core_clk;

    // converter clock, half period of three core cycles, can be paused
    always @(posedge core_clk)
    begin
        if (cclk_run)
        begin
            ccnt <= (ccnt == 2'h2) ? 2'h0 : ccnt + 2'h1;
            cclk <= (ccnt == 2'h2) ? ~cclk : cclk;
        end
    end

    task automatic end_of_test();
        $display("tests %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask

    // single-bit compare, widened on purpose
    task automatic chk_bit(input logic got, input logic exp);
        chk({11'h000, got}, {11'h000, exp});
    endtask

    // bounded wait for a new code pair
    task automatic wait_upd();
        int i;
        for (i = 0; i < 80; i++)
        begin
            @(posedge core_clk);
            #1;
            if (upd === 1'b1)
                return;
        end
        $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        fails++;
        end_of_test();
    endtask

    task automatic load_cfg(input logic four, input logic rev);
        @(posedge core_clk);
        cfg_load <= 1'b1;
        cfg_four <= four;
        cfg_rev  <= rev;
        @(posedge core_clk);
        cfg_load <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    // pause the converter so the single pop is not missed
    task automatic t_pair(input ddi_word_type a, input ddi_word_type b,
                          input ddi_word_type ea, input ddi_word_type eb);
        @(posedge core_clk);
        cclk_run <= 1'b0;
        i_ddi_host_model.send_pair(a, b, 1'b0);
        repeat (4) @(posedge core_clk);
        cclk_run <= 1'b1;
        wait_upd();
        chk(code_a, ea);
        chk(code_b, eb);
    endtask

    task automatic t_serial();
        chk_bit(sd_oe, 1'h0);
        chk_bit(rd_oe, 1'h0);
        @(posedge core_clk);
        rd_act <= 1'h1;
        rd_bit <= 1'h1;
        repeat (3) @(posedge core_clk);
        #1;
        chk_bit(sd_oe, 1'h1);
        chk_bit(sd_out, 1'h1);
        chk_bit(rd_oe, 1'h0);
        load_cfg(1'h1, 1'h0);
        chk_bit(sd_oe, 1'h0);
        chk_bit(rd_oe, 1'h1);
        chk_bit(rd_out, 1'h1);
        @(posedge core_clk);
        rd_bit   <= 1'h0;
        sdio_drv <= 1'h1;
        repeat (4) @(posedge core_clk);
        #1;
        chk_bit(rd_out, 1'h0);
        chk_bit(rx_bit, 1'h1);
        // asynchronous clear returns the port to 3-wire
        @(posedge core_clk);
        clear_n <= 1'h0;
        repeat (3) @(posedge core_clk);
        #1;
        chk_bit(rd_oe, 1'h0);
        chk_bit(sd_oe, 1'h1);
        @(posedge core_clk);
        clear_n  <= 1'h1;
        rd_act   <= 1'h0;
        sdio_drv <= 1'h0;
    endtask

    task automatic t_data();
        t_pair(12'h000, 12'hFFF, 12'h000, 12'hFFF);
        t_pair(12'h123, 12'hABC, 12'h123, 12'hABC);
        load_cfg(1'b0, 1'b1);
        t_pair(12'h001, 12'h003, 12'h800, 12'hC00);
        load_cfg(1'b0, 1'b0);
        t_pair(12'h001, 12'h003, 12'h001, 12'h003);
        @(posedge core_clk);
        gate <= 1'h0;
        t_pair(12'h7FF, 12'h456, 12'h000, 12'h000);
        @(posedge core_clk);
        gate <= 1'h1;
    endtask

    // fill while asleep until a pair is dropped, then flush by strobe
    task automatic t_fill();
        int i;
        int extra;
        extra = 0;
        @(posedge core_clk);
        sleep_in <= 1'h1;
        repeat (4) @(posedge core_clk);
        #1;
        chk_bit(sleep_st, 1'h1);
        for (i = 0; i < FIFO_DEPTH; i++)
            i_ddi_host_model.send_pair(i[11:0], ~i[11:0], 1'b0);
        repeat (4) @(posedge core_clk);
        #1;
        chk_bit(ovf, 1'h0);
        i_ddi_host_model.send_pair(12'h111, 12'h222, 1'b0);
        repeat (4) @(posedge core_clk);
        #1;
        chk_bit(ovf, 1'h1);
        i_ddi_host_model.send_pair(12'h5A5, 12'hA5A, 1'b1);
        repeat (4) @(posedge core_clk);
        #1;
        chk_bit(ovf, 1'h0);
        @(posedge core_clk);
        sleep_in <= 1'h0;
        wait_upd();
        chk_bit(sleep_st, 1'h0);
        chk(code_a, 12'h5A5);
        chk(code_b, 12'hA5A);
        for (i = 0; i < 40; i++)
        begin
            @(posedge core_clk);
            #1;
            if (upd === 1'b1)
                extra++;
        end
        chk(extra[11:0], 12'h000);
    endtask

    task automatic t_align();
        @(posedge core_clk);
        align <= 1'h1;
        repeat (14) @(posedge core_clk);
        #1;
        chk({10'h000, phase}, 12'h000);
        @(posedge core_clk);
        align <= 1'h0;
        repeat (10) @(posedge core_clk);
        #1;
        chk({11'h000, phase != 2'h0}, 12'h001);
    endtask

    // inputs idle at time zero, reset for twelve cycles
    initial
    begin
        core_clk = 1'b0;
        rst      = 1'b1;
        clear_n  = 1'b1;
        cfg_load = 1'b0;
        cfg_four = 1'b0;
        cfg_rev  = 1'b0;
        rd_act   = 1'b0;
        rd_bit   = 1'b0;
        sdio_drv = 1'b0;
        gate     = 1'b0;
        sleep_in = 1'b0;
        cclk     = 1'b0;
        align    = 1'b0;
        cclk_run = 1'b0;
        ccnt     = 2'h0;
        fails    = 0;
        n_tests  = 0;
        repeat (12) @(posedge core_clk);
        rst      <= 1'b0;
        gate     <= 1'b1;
        cclk_run <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        t_serial();
        t_data();
        t_fill();
        t_align();
        end_of_test();
    end
endmodule
